// ==== tap_pkg.sv ====
// Shared constants and types for the test access port and boundary scan block
package tap_pkg;

	// ----------------------------------------------------------------
	// Instruction register
	// ----------------------------------------------------------------
	localparam int IR_W = 16;
	localparam logic [15:0] IR_RESET = 16'h0000;
	localparam logic [15:0] IR_CAPTURE = 16'h0001;
	localparam logic [15:0] IR_EXTEST = 16'h0000;
	localparam logic [15:0] IR_SAMPLE = 16'h0002;
	localparam logic [15:0] IR_IDCODE = 16'h0004;
	localparam logic [15:0] IR_BYPASS = 16'hFFFF;
	localparam logic [15:0] IR_NVM_CTRL = 16'h0082;
	localparam logic [15:0] IR_NVM_DATA = 16'h0083;
	localparam logic [15:0] IR_NVM_ADDR = 16'h0084;

	// ----------------------------------------------------------------
	// Data register sizes and boundary chain layout
	// ----------------------------------------------------------------
	localparam int BSR_BITS = 134;
	localparam int ID_W = 32;
	localparam int NVM_CTRL_W = 8;
	localparam int NVM_DATA_W = 20;
	localparam int NVM_ADDR_W = 16;
	localparam int NPAD = 67;
	localparam int PAD_RST = 0;
	localparam int PAD_CAN_RECEIVE_PIN = 1;
	localparam int PAD_CAN_TRANSMIT_PIN = 2;
	localparam int PAD_PORT0 = 3;
	localparam int BIT_RST_OE_A = 0;
	localparam int BIT_RST_DAT_A = 1;
	localparam int BIT_RST_OE_B = 2;
	localparam int BIT_CAN_RECEIVE_PIN_OE = 4;
	localparam int BIT_CAN_TRANSMIT_PIN_OE = 6;
	localparam int BIT_XTAL = 8;
	localparam int BIT_WPU = 9;
	localparam int BIT_PORT_BASE = 10;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		st_reset = 4'h0, st_idle = 4'h1, st_sel_dr = 4'h2, st_cap_dr = 4'h3,
		st_sh_dr = 4'h4, st_ex1_dr = 4'h5, st_pa_dr = 4'h6, st_ex2_dr = 4'h7,
		st_upd_dr = 4'h8, st_sel_ir = 4'h9, st_cap_ir = 4'hA, st_sh_ir = 4'hB,
		st_ex1_ir = 4'hC, st_pa_ir = 4'hD, st_ex2_ir = 4'hE, st_upd_ir = 4'hF
	} tap_state_t;

	typedef struct packed {
		logic [NPAD-1:0] oe;
		logic [NPAD-1:0] dout;
	} pad_drive_t;

endpackage : tap_pkg

// ==== tap_boundary_scan.sv ====
// Test access port with instruction decode, boundary scan chain and selectable data registers
//
// How it works
// - Only tck, tms, tdi, tdo reach the block; the tester drives three, samples tdo.
// - Sixteen-state controller sequences capture, shift and update on standard states.
// - Instruction register is 16 bits, all zeros after reset, loads any code.
// - Code 0000 puts the boundary chain between tdi and tdo and drives pins.
// - Code 0002 samples pins and preloads update latches without driving pins.
// - Code 0004 selects the identification register.
// - Code FFFF selects the one-bit bypass register.
// - Code 0082 selects the nvm control register.
// - Code 0083 selects the nvm data register.
// - Code 0084 selects the nvm address register.
// - The boundary chain is a 134-bit shift register.
// - External test captures and updates; sample captures and preloads, pins stay core driven.
// - During external test every input to core logic reads as one.
// - Bits 0 and 2 capture core reset enable; bit 2 update drives reset pin enable.
// - Bits 1 and 3 capture reset pin level; bit 3 update gives reset pin value.
// - Bits 4,6 are CAN pin enables; bits 5,7 their input and output values.
// - Bit 8 captures the external clock pin; its update does nothing.
// - Bit 9 captures core weak pullup enable; update drives pullup enable of ports.
// - Port zero pins use enable and data bit pairs from bit 10 to 25.
// - Ports one to seven follow in 16-bit groups; chain length cuts port seven.
// - The identification register is 32 bits and shifts out on tdo.
`timescale 1ns/1ps

module tap_boundary_scan #(
	parameter int BSR_LEN = tap_pkg::BSR_BITS,
	parameter logic [31:0] ID_VALUE = 32'h0000_0001 // Arbitrary identification value, bit 0 set
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo_out,
	output logic tdo_oe,
	input wire logic [tap_pkg::NPAD-1:0] pad_in,
	input wire logic xtal_pin,
	output tap_pkg::pad_drive_t pad_drive,
	output logic wpu_pad_en,
	input wire tap_pkg::pad_drive_t core_drive,
	input wire logic core_wpu_en,
	output logic [tap_pkg::NPAD-1:0] core_pad_in,
	output logic core_xtal,
	output logic [tap_pkg::NVM_CTRL_W-1:0] nvm_control,
	output logic [tap_pkg::NVM_ADDR_W-1:0] nvm_address,
	output logic [tap_pkg::NVM_DATA_W-1:0] nvm_data_out
);
	import tap_pkg::*;

	// ----------------------------------------------------------------
	// Reset into the test clock domain
	// ----------------------------------------------------------------
	logic rst_tck_meta_reg;
	logic rst_tck_sync_reg;

	// Level crossing; the tester must clock tck a few times after rst to see it
	always_ff @(posedge tck) begin
		rst_tck_meta_reg <= rst;
		rst_tck_sync_reg <= rst_tck_meta_reg;
	end

	// ----------------------------------------------------------------
	// Controller state machine
	// ----------------------------------------------------------------
	tap_state_t state_reg;
	tap_state_t state_next;

	// Standard sixteen-state walk steered by tms alone
	always_comb begin
		case (state_reg)
			st_reset: state_next = tms ? st_reset : st_idle;
			st_idle: state_next = tms ? st_sel_dr : st_idle;
			st_sel_dr: state_next = tms ? st_sel_ir : st_cap_dr;
			st_cap_dr: state_next = tms ? st_ex1_dr : st_sh_dr;
			st_sh_dr: state_next = tms ? st_ex1_dr : st_sh_dr;
			st_ex1_dr: state_next = tms ? st_upd_dr : st_pa_dr;
			st_pa_dr: state_next = tms ? st_ex2_dr : st_pa_dr;
			st_ex2_dr: state_next = tms ? st_upd_dr : st_sh_dr;
			st_upd_dr: state_next = tms ? st_sel_dr : st_idle;
			st_sel_ir: state_next = tms ? st_reset : st_cap_ir;
			st_cap_ir: state_next = tms ? st_ex1_ir : st_sh_ir;
			st_sh_ir: state_next = tms ? st_ex1_ir : st_sh_ir;
			st_ex1_ir: state_next = tms ? st_upd_ir : st_pa_ir;
			st_pa_ir: state_next = tms ? st_ex2_ir : st_pa_ir;
			st_ex2_ir: state_next = tms ? st_upd_ir : st_sh_ir;
			st_upd_ir: state_next = tms ? st_sel_dr : st_idle;
			default: state_next = st_reset;
		endcase
	end

	// Five tms highs also reach reset, so no tester reset pin is needed
	always_ff @(posedge tck) begin
		if (rst_tck_sync_reg) begin
			state_reg <= st_reset;
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------------------------------
	// Instruction register and decode
	// ----------------------------------------------------------------
	logic [IR_W-1:0] ir_shift_reg;
	logic [IR_W-1:0] ir_reg;

	// Shift path captures the fixed pattern, shifts lsb first, loads on update
	always_ff @(posedge tck) begin
		if (state_reg == st_cap_ir) begin
			ir_shift_reg <= IR_CAPTURE;
		end else if (state_reg == st_sh_ir) begin
			ir_shift_reg <= {tdi, ir_shift_reg[IR_W-1:1]};
		end
	end

	always_ff @(posedge tck) begin
		if (rst_tck_sync_reg || state_reg == st_reset) begin
			ir_reg <= IR_RESET;
		end else if (state_reg == st_upd_ir) begin
			ir_reg <= ir_shift_reg;
		end
	end

	// Register selection; anything not recognised falls to bypass
	wire sel_extest = (ir_reg == IR_EXTEST);
	wire sel_bsr = sel_extest || (ir_reg == IR_SAMPLE);
	wire sel_id = (ir_reg == IR_IDCODE);
	wire sel_ctrl = (ir_reg == IR_NVM_CTRL);
	wire sel_data = (ir_reg == IR_NVM_DATA);
	wire sel_addr = (ir_reg == IR_NVM_ADDR);
	wire sel_bypass = !(sel_bsr || sel_id || sel_ctrl || sel_data || sel_addr);
	wire cap_dr = (state_reg == st_cap_dr);
	wire sh_dr = (state_reg == st_sh_dr);
	wire upd_dr = (state_reg == st_upd_dr);

	// ----------------------------------------------------------------
	// Boundary chain, identification and bypass
	// ----------------------------------------------------------------
	logic [BSR_LEN-1:0] cap_word;
	logic [BSR_LEN-1:0] cap_clk_reg;
	logic [BSR_LEN-1:0] cap_meta_reg;
	logic [BSR_LEN-1:0] cap_sync_reg;
	logic [BSR_LEN-1:0] bsr_shift_reg;
	logic [BSR_LEN-1:0] upd_reg;
	logic [ID_W-1:0] id_shift_reg;
	logic bypass_reg;
	logic extest_reg;

	// Captured pin states cross per bit; each bit is an independent level
	always_ff @(posedge tck) begin
		cap_meta_reg <= cap_clk_reg;
		cap_sync_reg <= cap_meta_reg;
	end

	always_ff @(posedge tck) begin
		if (cap_dr && sel_bsr) begin
			bsr_shift_reg <= cap_sync_reg;
		end else if (sh_dr && sel_bsr) begin
			bsr_shift_reg <= {tdi, bsr_shift_reg[BSR_LEN-1:1]};
		end
	end

	// Preload in sample mode fills the latches without touching the pins
	always_ff @(posedge tck) begin
		if (rst_tck_sync_reg) begin
			upd_reg <= '0;
		end else if (upd_dr && sel_bsr) begin
			upd_reg <= bsr_shift_reg;
		end
	end

	// Loads with the instruction itself, so the pins switch even if tck stops right after the frame
	always_ff @(posedge tck) begin
		if (rst_tck_sync_reg || state_reg == st_reset) begin
			extest_reg <= (IR_RESET == IR_EXTEST);
		end else if (state_reg == st_upd_ir) begin
			extest_reg <= (ir_shift_reg == IR_EXTEST);
		end
	end

	always_ff @(posedge tck) begin
		if (cap_dr && sel_id) begin
			id_shift_reg <= ID_VALUE;
		end else if (sh_dr && sel_id) begin
			id_shift_reg <= {tdi, id_shift_reg[ID_W-1:1]};
		end
	end

	always_ff @(posedge tck) begin
		if (cap_dr && sel_bypass) begin
			bypass_reg <= 1'b0;
		end else if (sh_dr && sel_bypass) begin
			bypass_reg <= tdi;
		end
	end

	// ----------------------------------------------------------------
	// Nonvolatile memory access registers
	// ----------------------------------------------------------------
	logic [NVM_CTRL_W-1:0] ctrl_shift_reg;
	logic [NVM_DATA_W-1:0] data_shift_reg;
	logic [NVM_ADDR_W-1:0] addr_shift_reg;

	// Command decoding of these words is left to the memory controller
	always_ff @(posedge tck) begin
		if (cap_dr && sel_ctrl) begin
			ctrl_shift_reg <= nvm_control;
		end else if (sh_dr && sel_ctrl) begin
			ctrl_shift_reg <= {tdi, ctrl_shift_reg[NVM_CTRL_W-1:1]};
		end
		if (cap_dr && sel_data) begin
			data_shift_reg <= nvm_data_out;
		end else if (sh_dr && sel_data) begin
			data_shift_reg <= {tdi, data_shift_reg[NVM_DATA_W-1:1]};
		end
		if (cap_dr && sel_addr) begin
			addr_shift_reg <= nvm_address;
		end else if (sh_dr && sel_addr) begin
			addr_shift_reg <= {tdi, addr_shift_reg[NVM_ADDR_W-1:1]};
		end
	end

	always_ff @(posedge tck) begin
		if (rst_tck_sync_reg) begin
			nvm_control <= '0;
			nvm_data_out <= '0;
			nvm_address <= '0;
		end else if (upd_dr) begin
			if (sel_ctrl) nvm_control <= ctrl_shift_reg;
			if (sel_data) nvm_data_out <= data_shift_reg;
			if (sel_addr) nvm_address <= addr_shift_reg;
		end
	end

	// ----------------------------------------------------------------
	// Test data out
	// ----------------------------------------------------------------
	wire dr_lsb = sel_bsr ? bsr_shift_reg[0] :
		sel_id ? id_shift_reg[0] :
		sel_ctrl ? ctrl_shift_reg[0] :
		sel_data ? data_shift_reg[0] :
		sel_addr ? addr_shift_reg[0] : bypass_reg;
	wire tdo_next = (state_reg == st_sh_ir) ? ir_shift_reg[0] : dr_lsb;
	wire tdo_en_next = (state_reg == st_sh_ir) || sh_dr;

	// Falling edge launch gives the tester half a period of hold on tdo
	always_ff @(negedge tck) begin
		if (rst_tck_sync_reg) begin
			tdo_out <= 1'b0;
			tdo_oe <= 1'b0;
		end else begin
			tdo_out <= tdo_next;
			tdo_oe <= tdo_en_next;
		end
	end

	// ----------------------------------------------------------------
	// Pin side in the system clock domain
	// ----------------------------------------------------------------
	logic [NPAD-1:0] pad_meta_reg;
	logic [NPAD-1:0] pad_sync_reg;
	logic xtal_meta_reg;
	logic xtal_sync_reg;
	logic [BSR_LEN-1:0] upd_meta_reg;
	logic [BSR_LEN-1:0] upd_sync_reg;
	logic ext_meta_reg;
	logic ext_sync_reg;
	pad_drive_t ext_drive;

	// Pins and tck-domain levels each pass two flops before use
	always_ff @(posedge clk) begin
		pad_meta_reg <= pad_in;
		pad_sync_reg <= pad_meta_reg;
		xtal_meta_reg <= xtal_pin;
		xtal_sync_reg <= xtal_meta_reg;
		upd_meta_reg <= upd_reg;
		upd_sync_reg <= upd_meta_reg;
		ext_meta_reg <= extest_reg;
		ext_sync_reg <= ext_meta_reg;
	end

	// Fixed cells: first reset pair, clock pin, pullup enable
	assign cap_word[BIT_RST_OE_A] = core_drive.oe[PAD_RST];
	assign cap_word[BIT_RST_DAT_A] = pad_sync_reg[PAD_RST];
	assign cap_word[BIT_XTAL] = xtal_sync_reg;
	assign cap_word[BIT_WPU] = core_wpu_en;

	// Each pad inside the chain owns an enable bit and the data bit above it
	for (genvar p = 0; p < NPAD; p++) begin : g_pad
		localparam int OB = (p == PAD_RST) ? BIT_RST_OE_B :
			(p == PAD_CAN_RECEIVE_PIN) ? BIT_CAN_RECEIVE_PIN_OE :
			(p == PAD_CAN_TRANSMIT_PIN) ? BIT_CAN_TRANSMIT_PIN_OE : BIT_PORT_BASE + 2 * (p - PAD_PORT0);
		if (OB + 1 < BSR_LEN) begin : g_cell
			assign cap_word[OB] = core_drive.oe[p];
			assign cap_word[OB + 1] = pad_sync_reg[p];
			assign ext_drive.oe[p] = upd_sync_reg[OB];
			assign ext_drive.dout[p] = upd_sync_reg[OB + 1];
		end else begin : g_none
			// Pads past the end of the chain float while under test
			assign ext_drive.oe[p] = 1'b0;
			assign ext_drive.dout[p] = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		cap_clk_reg <= cap_word;
	end

	// Pin and core outputs are registered so they never glitch on mode change
	always_ff @(posedge clk) begin
		if (rst) begin
			pad_drive <= '0;
			wpu_pad_en <= 1'b0;
			core_pad_in <= '0;
			core_xtal <= 1'b0;
		end else if (ext_sync_reg) begin
			pad_drive <= ext_drive;
			wpu_pad_en <= upd_sync_reg[BIT_WPU];
			core_pad_in <= '1;
			core_xtal <= 1'b1;
		end else begin
			pad_drive <= core_drive;
			wpu_pad_en <= core_wpu_en;
			core_pad_in <= pad_sync_reg;
			core_xtal <= xtal_sync_reg;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence tms_held_s;
		tms [*5];
	endsequence

	tap_reset_a: assert property (@(posedge tck) disable iff (rst_tck_sync_reg)
		tms_held_s |=> state_reg == st_reset) else $error("five tms highs did not reach reset");
	ir_reset_a: assert property (@(posedge tck) disable iff (rst_tck_sync_reg)
		state_reg == st_reset |=> ir_reg == IR_RESET) else $error("instruction not cleared in reset");
	ir_update_a: assert property (@(posedge tck) disable iff (rst_tck_sync_reg)
		state_reg == st_upd_ir |=> ir_reg == $past(ir_shift_reg)) else $error("instruction not loaded");
	bsr_capture_a: assert property (@(posedge tck) disable iff (rst_tck_sync_reg)
		cap_dr && sel_bsr |=> bsr_shift_reg == $past(cap_sync_reg)) else $error("boundary capture wrong");
	id_capture_a: assert property (@(posedge tck) disable iff (rst_tck_sync_reg)
		cap_dr && sel_id |=> sh_dr |-> id_shift_reg == ID_VALUE) else $error("identification capture wrong");
	bypass_path_a: assert property (@(posedge tck) disable iff (rst_tck_sync_reg)
		sh_dr && sel_bypass |=> bypass_reg == $past(tdi)) else $error("bypass bit not shifted");
	nvm_update_a: assert property (@(posedge tck) disable iff (rst_tck_sync_reg)
		upd_dr && sel_ctrl |=> nvm_control == $past(ctrl_shift_reg)) else $error("control update lost");
	force_ones_a: assert property (@(posedge clk) disable iff (rst)
		ext_sync_reg |=> core_pad_in == '1 && core_xtal) else $error("core inputs not forced high");
	core_pass_a: assert property (@(posedge clk) disable iff (rst)
		!ext_sync_reg |=> pad_drive == $past(core_drive)) else $error("pins not core driven");
	rst_pin_a: assert property (@(posedge clk) disable iff (rst)
		ext_sync_reg |=> pad_drive.oe[PAD_RST] == $past(upd_sync_reg[BIT_RST_OE_B]))
		else $error("reset pin enable not from chain");
	wpu_drive_a: assert property (@(posedge clk) disable iff (rst)
		ext_sync_reg |=> wpu_pad_en == $past(upd_sync_reg[BIT_WPU])) else $error("pullup enable not from chain");

endmodule : tap_boundary_scan

// ==== tap_tester.sv ====
// Behavioural test controller model driving the four-wire test port
`timescale 1ns/1ps

module tap_tester (
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo
);
	// ----------------------------------------------------------------
	// Link pins
	// ----------------------------------------------------------------
	// Link clock rests low between frames, like a real tester
	initial begin
		tck = 1'h0;
		tms = 1'h1;
		tdi = 1'h0;
	end

	// One link cycle: change after the fall, sample tdo just before the rise
	task automatic tick(input logic tms_v, input logic tdi_v, output logic tdo_v);
		tms = tms_v;
		tdi = tdi_v;
		#5;
		tdo_v = tdo;
		tck = 1'h1;
		#6;
		tck = 1'h0;
		#1;
	endtask : tick

	// ----------------------------------------------------------------
	// State sequencing
	// ----------------------------------------------------------------
	// Five cycles with tms high reach reset from any state, then park in idle
	task automatic reset_tap();
		logic d;
		repeat (5) tick(1'h1, ~tdi, d);
		tick(1'h0, ~tdi, d);
	endtask : reset_tap

	// Idle cycles give the pin synchronisers time before a capture
	task automatic idle(input int n);
		logic d;
		repeat (n) tick(1'h0, ~tdi, d);
	endtask : idle

	// Full scan from idle back to idle; tdi toggles outside shift so stale data never looks valid
	task automatic scan(input logic is_ir, input int n, input logic [133:0] din, output logic [133:0] dout);
		logic d;
		dout = '0;
		tick(1'h1, ~tdi, d);
		if (is_ir) begin
			tick(1'h1, ~tdi, d);
		end
		tick(1'h0, ~tdi, d);
		tick(1'h0, ~tdi, d);
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, din[i], dout[i]);
		end
		tick(1'h1, ~tdi, d);
		tick(1'h0, ~tdi, d);
	endtask : scan
endmodule : tap_tester

// ==== tb_jtag_tap_boundary_scan.sv ====
// Self-checking testbench for the test access port and boundary scan block
`timescale 1ns/1ps

module tb_jtag_tap_boundary_scan;
	import tap_pkg::*;
	localparam logic [31:0] ID_TB = 32'h0A5C_3E11; // Arbitrary identification value
	localparam logic [133:0] P_PRE = {2'h1, {33{4'h6}}};
	localparam logic [133:0] Q_EXT = {2'h2, {33{4'hB}}};
	logic clk, rst, tck, tms, tdi, tdo_out, tdo_oe, xtal_pin, core_wpu_en, wpu_pad_en, core_xtal;
	logic [NPAD-1:0] pad_in, core_pad_in;
	pad_drive_t pad_drive, core_drive;
	logic [NVM_CTRL_W-1:0] nvm_control;
	logic [NVM_ADDR_W-1:0] nvm_address;
	logic [NVM_DATA_W-1:0] nvm_data_out;
	logic [133:0] got;
	logic [15:0] codes [0:1];
	logic [15:0] nvm_code [0:2];
	int nvm_w [0:2];
	logic [133:0] nvm_val [0:2];
	int n_errors = 0;
	int compares = 0;

	tap_boundary_scan #(.ID_VALUE(ID_TB)) u_dut (.clk, .rst, .tck, .tms, .tdi, .tdo_out, .tdo_oe, .pad_in,
		.xtal_pin, .pad_drive, .wpu_pad_en, .core_drive, .core_wpu_en, .core_pad_in, .core_xtal,
		.nvm_control, .nvm_address, .nvm_data_out);
	// A released tdo line shows the inverse, so a missing output enable garbles shifted data
	wire tdo_line = tdo_oe ? tdo_out : !tdo_out;
	tap_tester u_tester (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_line));

	// System clock, 40 ns period
	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic test_done();
		if (n_errors == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : test_done

	task automatic chk(input logic [133:0] g, input logic [133:0] e);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	// Outputs are looked at just after the clock edge, never in its own time step
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : settle

	// Every instruction load also checks the fixed capture pattern
	task automatic ir_load(input logic [15:0] code);
		logic [133:0] v;
		u_tester.scan(1'h1, 16, 134'(code), v);
		chk(v, 134'(IR_CAPTURE));
		chk(134'(tdo_oe), 134'h0);
	endtask : ir_load

	task automatic dr(input int n, input logic [133:0] din, output logic [133:0] dout);
		u_tester.scan(1'h0, n, din, dout);
	endtask : dr

	// Chain position of a pad's enable bit; its data bit follows
	function automatic int bitpos(input int p);
		return (p == 0) ? 2 : ((p < 3) ? 2 * p + 2 : 2 * p + 4);
	endfunction : bitpos

	function automatic logic [133:0] cap_exp();
		logic [133:0] v;
		v = '0;
		for (int p = 0; p < 65; p++) begin
			v[bitpos(p)] = core_drive.oe[p];
			v[bitpos(p) + 1] = pad_in[p];
		end
		v[0] = core_drive.oe[PAD_RST];
		v[1] = pad_in[PAD_RST];
		v[8] = xtal_pin;
		v[9] = core_wpu_en;
		return v;
	endfunction : cap_exp

	// Top two port pads have no chain bits: enables low, values left open
	function automatic pad_drive_t drv_exp(input logic [133:0] q);
		pad_drive_t e;
		e = '0;
		for (int p = 0; p < 65; p++) begin
			e.oe[p] = q[bitpos(p)];
			e.dout[p] = q[bitpos(p) + 1];
		end
		return e;
	endfunction : drv_exp

	function automatic pad_drive_t masked(input pad_drive_t d);
		pad_drive_t m;
		m = d;
		m.dout[66:65] = 2'h0;
		return m;
	endfunction : masked

	// New pin levels, then time for the clock register and link synchronisers
	task automatic set_pins(input logic inv);
		@(posedge clk);
		#1;
		pad_in = {3'h5, 64'hC3A5_0F96_1E2D_7B48} ^ {NPAD{inv}};
		core_drive.oe = {3'h2, 64'h9D41_66E3_05BF_2AC8} ^ {NPAD{inv}};
		core_drive.dout = ~pad_in;
		xtal_pin = ~inv;
		core_wpu_en = inv;
		repeat (4) @(posedge clk);
		u_tester.idle(3);
	endtask : set_pins

	// ----------------------------------------------------------------
	// Watchdog and main sequence
	// ----------------------------------------------------------------
	initial begin
		#200000;
		n_errors++;
		test_done();
	end

	initial begin
		rst = 1'h1;
		pad_in = '0;
		core_drive = '0;
		xtal_pin = 1'h0;
		core_wpu_en = 1'h0;
		codes = '{IR_BYPASS, 16'h0055};
		nvm_code = '{IR_NVM_CTRL, IR_NVM_DATA, IR_NVM_ADDR};
		nvm_w = '{8, 20, 16};
		nvm_val = '{134'hA5, 134'h5_3C69, 134'hC3E1};
		fork
			begin
				repeat (12) @(posedge clk);
				#1;
				rst = 1'h0;
			end
			u_tester.reset_tap();
		join
		u_tester.idle(4);
		// Reset leaves the external test code loaded: core sees ones, pad enables low
		settle(5);
		chk(134'({core_xtal, core_pad_in}), 134'({1'h1, {NPAD{1'h1}}}));
		chk(134'(pad_drive.oe), 134'h0);
		// Identification register
		ir_load(IR_IDCODE);
		dr(32, 134'h0, got);
		chk(got, 134'(ID_TB));
		// Bypass and an undefined code both give one bit that captures zero
		for (int k = 0; k < 2; k++) begin
			ir_load(codes[k]);
			dr(8, 134'h96, got);
			chk(got, 134'h2C);
		end
		// Storage registers: load, then read back the held value and check the port
		for (int k = 0; k < 3; k++) begin
			ir_load(nvm_code[k]);
			dr(nvm_w[k], nvm_val[k], got);
			dr(nvm_w[k], nvm_val[k], got);
			chk(got, nvm_val[k]);
			got = (k == 0) ? 134'(nvm_control) : ((k == 1) ? 134'(nvm_data_out) : 134'(nvm_address));
			chk(got, nvm_val[k]);
		end
		// Sample: capture the pins, preload the latches, pins stay with the core
		set_pins(1'h0);
		ir_load(IR_SAMPLE);
		dr(134, P_PRE, got);
		chk(got, cap_exp());
		settle(5);
		chk(pad_drive, core_drive);
		chk(134'({wpu_pad_en, core_xtal, core_pad_in}), 134'({core_wpu_en, xtal_pin, pad_in}));
		// External test: preloaded latches reach the pins at once
		ir_load(IR_EXTEST);
		settle(5);
		chk(masked(pad_drive), drv_exp(P_PRE));
		chk(134'({wpu_pad_en, core_xtal, core_pad_in}), 134'({P_PRE[9], 1'h1, {NPAD{1'h1}}}));
		// External test: capture new pins and update all drives over the full chain
		set_pins(1'h1);
		dr(134, Q_EXT, got);
		chk(got, cap_exp());
		settle(5);
		chk(masked(pad_drive), drv_exp(Q_EXT));
		chk(134'({wpu_pad_en, core_xtal}), 134'({Q_EXT[9], 1'h1}));
		test_done();
	end
endmodule : tb_jtag_tap_boundary_scan
